// ===== rtl/pcs_link_status_gating.sv
// Link qualification, status reporting and GMII gating of a PCS
// Summary of operation
// - No client frame reaches the line while no link exists, unless unidirectional control is set.
// - Unidirectional control lets client frames out without a link.
// - Isolate comes up active after reset and stays until cleared.
// - While isolated, nothing crosses the client GMII either way.
// - A bit error during the handshake (detect or acknowledge) restarts negotiation from the start.
// - Negotiation complete shows at status bit 5 when negotiation ends.
// - Link status shows at status bit 2 and status vector bit 1.
// - Status vector bit 0 is high once receive sync is established.
// - Signal present low holds the sync machine in loss-of-sync.
// - Received bit errors inside a frame (receive enable high) are flagged to the MAC as frame errors.
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module pcs_link_status_gating
  import pcs_link_pkg::*;
#(
  parameter int LINK_TIMER = LINK_TIMER_CYC
)
(
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Optical module signal present pin
  input  wire logic        signal_present,
  // Receive code-group indications from the decoder
  input  wire logic        rx_comma,
  input  wire logic        rx_code_err,
  input  wire logic        rx_ability,
  // Datapaths
  input  wire gmii_type    client_tx,
  output gmii_type         line_tx,
  input  wire gmii_type    line_rx,
  output gmii_type         client_rx,
  // Status and interrupt
  output logic [1:0]       status_vec,
  output logic             irq
);

  localparam int TW = $clog2(LINK_TIMER + 1);

  // Elaboration check on the timer length
  if (LINK_TIMER < 2) begin : g_bad_timer
    $error("LINK_TIMER must be at least 2");
  end

  logic           sig_m_q;
  logic           sig_s_q;
  sync_state_type sync_state_q;
  logic [2:0]     sync_cnt_q;
  an_state_type   an_state_q;
  logic [TW-1:0]  timer_q;
  logic           isolate_q;
  logic           unidir_q;
  logic           an_en_q;
  logic [2:0]     irq_stat_q;
  logic [2:0]     irq_mask_q;
  logic           link_d;
  logic           link_q;
  logic           anc_q;
  logic           an_err;
  logic           timer_done;
  logic           allow_tx;
  logic           aw_got_q;
  logic           w_got_q;
  logic [7:0]     awaddr_q;
  logic [31:0]    wdata_q;
  logic [3:0]     wstrb_q;
  logic           wr_fire;
  logic           wr_ctrl;
  logic           an_rst_req;
  logic [2:0]     irq_set;
  logic [2:0]     irq_clr;
  logic [31:0]    rd_val;
  logic [7:0]     mask_byte;
  logic           rd_ok;
  gmii_type       line_tx_q;
  gmii_type       client_rx_q;
  logic [1:0]     status_vec_q;
  logic           irq_q;

  // Byte lane 0 of the write data under its strobe
  function automatic logic [7:0] lane0(input logic [31:0] d,
                                       input logic [3:0]  s,
                                       input logic [7:0]  old);
    lane0 = s[0] ? d[7:0] : old;
  endfunction

  // Two-flop synchroniser for the pin
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sig_m_q <= 1'b0;
      sig_s_q <= 1'b0;
    end
    else
    begin
      sig_m_q <= signal_present;
      sig_s_q <= sig_m_q;
    end
  end

  // Receive synchronisation machine
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync_state_q <= SY_LOS;
      sync_cnt_q   <= 3'h0;
    end
    else if (!sig_s_q)
    begin
      sync_state_q <= SY_LOS;
      sync_cnt_q   <= 3'h0;
    end
    else
    begin
      case (sync_state_q)
        SY_LOS:
        begin
          if (rx_comma)
          begin
            sync_state_q <= SY_ACQ;
            sync_cnt_q   <= 3'h1;
          end
        end
        SY_ACQ:
        begin
          if (rx_code_err)
          begin
            sync_state_q <= SY_LOS;
            sync_cnt_q   <= 3'h0;
          end
          else if (rx_comma && sync_cnt_q == SYNC_ACQ_COMMAS - 3'h1)
          begin
            sync_state_q <= SY_SYNC;
            sync_cnt_q   <= 3'h0;
          end
          else if (rx_comma)
            sync_cnt_q <= sync_cnt_q + 3'h1;
        end
        default:
        begin
          if (rx_code_err && sync_cnt_q == SYNC_LOSS_ERRS - 3'h1)
          begin
            sync_state_q <= SY_LOS;
            sync_cnt_q   <= 3'h0;
          end
          else if (rx_code_err)
            sync_cnt_q <= sync_cnt_q + 3'h1;
          else if (rx_comma)
            sync_cnt_q <= 3'h0;
        end
      endcase
    end
  end

  // Negotiation handshake states and error detection
  assign timer_done = (timer_q == TW'(LINK_TIMER - 1));
  assign an_err = rx_code_err && (an_state_q == AN_DETECT ||
                                  an_state_q == AN_ACK);

  // Auto-negotiation machine with link timer
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      an_state_q <= AN_OFF;
      timer_q    <= '0;
    end
    else if (!an_en_q)
    begin
      an_state_q <= AN_OFF;
      timer_q    <= '0;
    end
    else if (an_rst_req || sync_state_q != SY_SYNC || an_err)
    begin
      an_state_q <= AN_RESTART;
      timer_q    <= '0;
    end
    else
    begin
      case (an_state_q)
        AN_OFF, AN_RESTART, AN_ACK:
        begin
          if (an_state_q == AN_OFF)
            an_state_q <= AN_RESTART;
          else if (timer_done)
          begin
            an_state_q <= (an_state_q == AN_ACK) ? AN_DONE : AN_DETECT;
            timer_q    <= '0;
          end
          else
            timer_q <= timer_q + TW'(1);
        end
        AN_DETECT:
        begin
          if (rx_ability)
            an_state_q <= AN_ACK;
        end
        default:
          an_state_q <= AN_DONE;
      endcase
    end
  end

  // Link exists with sync and finished or disabled negotiation
  assign link_d = (sync_state_q == SY_SYNC) &&
                  (!an_en_q || an_state_q == AN_DONE);

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      link_q <= 1'b0;
      anc_q  <= 1'b0;
    end
    else
    begin
      link_q <= link_d;
      anc_q  <= an_en_q && an_state_q == AN_DONE;
    end
  end

  // Transmit gating and receive marking
  assign allow_tx = (link_q || unidir_q) && !isolate_q;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      line_tx_q   <= '0;
      client_rx_q <= '0;
    end
    else
    begin
      line_tx_q <= allow_tx ? client_tx : '0;
      if (isolate_q)
        client_rx_q <= '0;
      else
      begin
        client_rx_q    <= line_rx;
        client_rx_q.er <= line_rx.er ||
                          (line_rx.en && rx_code_err);
      end
    end
  end

  // Status vector output
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      status_vec_q <= 2'h0;
    else
    begin
      status_vec_q[0] <= sync_state_q == SY_SYNC;
      status_vec_q[1] <= link_q;
    end
  end

  // AXI write acceptance
  assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
  assign wr_ctrl = wr_fire && awaddr_q == CTRL_OFS;
  assign an_rst_req = wr_ctrl && wstrb_q[0] && wdata_q[CTRL_AN_RST_BIT];

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
    end
    else
    begin
      if (!aw_got_q && !s_axi_bvalid)
        s_axi_awready <= !(s_axi_awvalid && s_axi_awready);
      if (!w_got_q && !s_axi_bvalid)
        s_axi_wready <= !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q == CTRL_OFS || awaddr_q == STATUS_OFS ||
                         awaddr_q == IRQ_STAT_OFS ||
                         awaddr_q == IRQ_MASK_OFS) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Mask byte after its strobe; a call result cannot be part-selected
  assign mask_byte = lane0(wdata_q, wstrb_q, {5'h00, irq_mask_q});

  // Control and mask registers
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      isolate_q  <= CTRL_ISOLATE_RST;
      unidir_q   <= CTRL_UNIDIR_RST;
      an_en_q    <= CTRL_AN_EN_RST;
      irq_mask_q <= IRQ_MASK_RST;
    end
    else if (wr_fire && wstrb_q[0])
    begin
      if (awaddr_q == CTRL_OFS)
      begin
        isolate_q <= wdata_q[CTRL_ISOLATE_BIT];
        unidir_q  <= wdata_q[CTRL_UNIDIR_BIT];
        an_en_q   <= wdata_q[CTRL_AN_EN_BIT];
      end
      else if (awaddr_q == IRQ_MASK_OFS)
        irq_mask_q <= mask_byte[2:0];
    end
  end

  // Sticky events; a new event wins over a clear
  assign irq_set[IRQ_ANC_BIT]   = (an_en_q && an_state_q == AN_DONE) &&
                                  !anc_q;
  assign irq_set[IRQ_LINK_BIT]  = link_d != link_q;
  assign irq_set[IRQ_ANERR_BIT] = an_en_q && an_err;
  assign irq_clr = (wr_fire && wstrb_q[0] && awaddr_q == IRQ_STAT_OFS) ?
                   wdata_q[2:0] : 3'h0;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_stat_q <= 3'h0;
      irq_q      <= 1'b0;
    end
    else
    begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      irq_q      <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Read data multiplexer
  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    if (s_axi_araddr == CTRL_OFS)
    begin
      rd_val[CTRL_ISOLATE_BIT] = isolate_q;
      rd_val[CTRL_UNIDIR_BIT]  = unidir_q;
      rd_val[CTRL_AN_EN_BIT]   = an_en_q;
    end
    else if (s_axi_araddr == STATUS_OFS)
    begin
      rd_val[STAT_SYNC_BIT] = sync_state_q == SY_SYNC;
      rd_val[STAT_LINK_BIT] = link_q;
      rd_val[STAT_ANC_BIT]  = anc_q;
    end
    else if (s_axi_araddr == IRQ_STAT_OFS)
      rd_val[2:0] = irq_stat_q;
    else if (s_axi_araddr == IRQ_MASK_OFS)
      rd_val[2:0] = irq_mask_q;
    else
      rd_ok = 1'b0;
  end

  // AXI read channel
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  assign line_tx    = line_tx_q;
  assign client_rx  = client_rx_q;
  assign status_vec = status_vec_q;
  assign irq        = irq_q;

  // Checks
  sequence s_hs_err;
    (an_state_q == AN_DETECT || an_state_q == AN_ACK) && rx_code_err &&
    an_en_q;
  endsequence

  sequence s_ack_end;
    an_state_q == AN_ACK && timer_done && !rx_code_err && an_en_q &&
    !an_rst_req && sync_state_q == SY_SYNC;
  endsequence

  a_tx_block: assert property (@(posedge mclk) disable iff (!arst_n)
    !link_q && !unidir_q |=> line_tx_q == '0)
    else $error("client frame passed without link");
  a_unidir_pass: assert property (@(posedge mclk) disable iff (!arst_n)
    unidir_q && !isolate_q |=> line_tx_q == $past(client_tx))
    else $error("unidirectional transmit not passed");
  a_isolate_sticks: assert property (@(posedge mclk) disable iff (!arst_n)
    isolate_q && !wr_ctrl |=> isolate_q)
    else $error("isolate cleared without a write");
  a_isolate_rx: assert property (@(posedge mclk) disable iff (!arst_n)
    isolate_q |=> client_rx_q == '0 && line_tx_q == '0)
    else $error("data crossed an isolated GMII");
  a_an_err_restart: assert property (@(posedge mclk) disable iff (!arst_n)
    s_hs_err |=> an_state_q == AN_RESTART ##1 timer_q == TW'(1))
    else $error("bit error did not restart negotiation");
  a_an_done_bit: assert property (@(posedge mclk) disable iff (!arst_n)
    s_ack_end |=> an_state_q == AN_DONE ##1 anc_q)
    else $error("negotiation complete not reported");
  a_link_vec: assert property (@(posedge mclk) disable iff (!arst_n)
    link_d |=> link_q ##1 status_vec_q[1])
    else $error("link status not on vector bit 1");
  a_sync_vec: assert property (@(posedge mclk) disable iff (!arst_n)
    1'b1 |=> status_vec_q[0] == $past(sync_state_q == SY_SYNC))
    else $error("sync not on vector bit 0");
  a_sig_los: assert property (@(posedge mclk) disable iff (!arst_n)
    !sig_s_q |=> sync_state_q == SY_LOS ##1 !status_vec_q[0])
    else $error("sync machine left loss of sync");
  a_rx_err_mark: assert property (@(posedge mclk) disable iff (!arst_n)
    !isolate_q && line_rx.en && rx_code_err |=> client_rx_q.er)
    else $error("receive bit error not marked");

endmodule // pcs_link_status_gating

`default_nettype wire

// ===== rtl/pcs_link_pkg.sv
// Constants and carrier types for the link status and gating block
package pcs_link_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] STATUS_OFS   = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;

  // Control fields
  localparam int CTRL_ISOLATE_BIT = 0;
  localparam int CTRL_UNIDIR_BIT  = 1;
  localparam int CTRL_AN_EN_BIT   = 2;
  localparam int CTRL_AN_RST_BIT  = 3;
  localparam logic CTRL_ISOLATE_RST = 1'b1;
  localparam logic CTRL_UNIDIR_RST  = 1'b0;
  localparam logic CTRL_AN_EN_RST   = 1'b1;

  // Status fields
  localparam int STAT_SYNC_BIT = 0;
  localparam int STAT_LINK_BIT = 2;
  localparam int STAT_ANC_BIT  = 5;

  // Interrupt fields
  localparam int IRQ_ANC_BIT  = 0;
  localparam int IRQ_LINK_BIT = 1;
  localparam int IRQ_ANERR_BIT = 2;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  // Synchronisation thresholds
  localparam logic [2:0] SYNC_ACQ_COMMAS = 3'h3;
  localparam logic [2:0] SYNC_LOSS_ERRS  = 3'h4;

  // Link timer
  localparam int CLK_PERIOD_NS  = 25;
  localparam int LINK_TIMER_NS  = 10000000;
  localparam int LINK_TIMER_CYC =
    (LINK_TIMER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // One GMII direction
  typedef struct packed {
    logic [7:0] d;
    logic       en;
    logic       er;
  } gmii_type;

  typedef enum logic [1:0] {SY_LOS, SY_ACQ, SY_SYNC} sync_state_type;
  typedef enum logic [2:0] {AN_OFF, AN_RESTART, AN_DETECT, AN_ACK,
                            AN_DONE} an_state_type;

endpackage

// ===== verif/link_partner.sv
// Behavioural far-end link partner feeding the receive indications
`timescale 1ns/10ps
`default_nettype none

module link_partner
  import pcs_link_pkg::*;
(
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic light,
  input  wire logic neg,
  input  wire logic err_on,
  output logic      signal_present,
  output logic      rx_comma,
  output logic      rx_code_err,
  output logic      rx_ability,
  output gmii_type  line_rx
);

  logic [7:0] cnt_q;

  // Signal present follows light with true polarity
  assign signal_present = light;
  // Commas every other cycle, ability words only when negotiating
  assign rx_comma    = light & cnt_q[0];
  assign rx_ability  = light & neg & (cnt_q[1:0] == 2'h3);
  assign rx_code_err = light & err_on;

  // Frame words; the bus toggles when dark so it never holds a value
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_q   <= 8'h00;
      line_rx <= '0;
    end
    else
    begin
      cnt_q      <= cnt_q + 8'h01;
      line_rx.d  <= light ? cnt_q : ~line_rx.d;
      line_rx.en <= light;
      line_rx.er <= 1'b0;
    end
  end

endmodule // link_partner
`default_nettype wire

// ===== verif/tb_pcs_link_status_gating.sv
// Self-checking bench for the link status and gating block
`timescale 1ns/10ps
`default_nettype none

module tb_pcs_link_status_gating
  import pcs_link_pkg::*;
();

  localparam int LT = 8;
  logic        mclk, arst_n, light, neg, err_on, irq;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        sig_p, comma, cerr, abil;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd, seed;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, sv;
  gmii_type    ctx, ltx, lrx, crx;
  int          n_fail, n_checks;

  pcs_link_status_gating #(.LINK_TIMER(LT)) DUT
  (
    .mclk(mclk), .arst_n(arst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .signal_present(sig_p), .rx_comma(comma),
    .rx_code_err(cerr), .rx_ability(abil), .client_tx(ctx),
    .line_tx(ltx), .line_rx(lrx), .client_rx(crx), .status_vec(sv),
    .irq(irq)
  );

  link_partner PEER
  (
    .mclk(mclk), .arst_n(arst_n), .light(light), .neg(neg),
    .err_on(err_on), .signal_present(sig_p), .rx_comma(comma),
    .rx_code_err(cerr), .rx_ability(abil), .line_rx(lrx)
  );

  // Clock at 40 MHz
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  // Expected line word: passed through only when allowed
  function automatic logic [9:0] exp_tx(input logic ok, input logic [9:0] v);
    return ok ? v : 10'h000;
  endfunction

  function automatic logic [31:0] stat_exp(input logic s, l, a);
    return (32'(s) << STAT_SYNC_BIT) | (32'(l) << STAT_LINK_BIT) |
           (32'(a) << STAT_ANC_BIT);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (n_fail == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Write; both channels offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever
    begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
        break;
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        input logic [1:0] er);
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    d = 32'h0;
    forever
    begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        rready <= 1'b0;
        d = rdata;
        chk({30'h0, rresp}, {30'h0, er});
        break;
      end
    end
  endtask

  // Bounded wait for one status vector bit
  task automatic wait_sv(input int b, input logic v, input int lim);
    int n;
    n = 0;
    while (sv[b] !== v && n < lim)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk({31'h0, sv[b]}, {31'h0, v});
  endtask

  // Random client words against the expected line and client words
  task automatic check_tx(input logic ok, input logic iso);
    logic [9:0] v;
    repeat (6)
    begin
      @(posedge mclk);
      seed = xs(seed);
      v = seed[9:0];
      ctx <= v;
      @(posedge mclk);
      #1;
      chk({22'h0, ltx}, {22'h0, exp_tx(ok, v)});
      if (iso) chk({22'h0, crx}, 32'h0);
    end
  endtask

  task automatic err_pulse();
    @(posedge mclk);
    err_on <= 1'b1;
    @(posedge mclk);
    err_on <= 1'b0;
    #1;
  endtask

  // Watchdog against a hang
  initial
  begin
    #200000;
    n_fail++;
    give_verdict();
  end

  // Main sequence
  initial
  begin
    {arst_n, light, neg, err_on, awvalid, wvalid, bready} = '0;
    {arvalid, rready, awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    ctx = '0;
    n_fail = 0;
    n_checks = 0;
    seed = 32'h5963605c;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    axi_rd(CTRL_OFS, rd, RESP_OKAY);
    chk(rd, {29'h0, CTRL_AN_EN_RST, CTRL_UNIDIR_RST, CTRL_ISOLATE_RST});
    axi_rd(IRQ_MASK_OFS, rd, RESP_OKAY);
    chk(rd, {29'h0, IRQ_MASK_RST});
    axi_wr(8'h40, 32'h0, RESP_SLVERR);
    axi_rd(8'h40, rd, RESP_SLVERR);
    chk(rd, 32'h0);
    // Isolated with unidirectional set and a live link
    axi_wr(CTRL_OFS, 32'h3, RESP_OKAY);
    light <= 1'b1;
    wait_sv(0, 1'b1, 60);
    wait_sv(1, 1'b1, 20);
    check_tx(1'b0, 1'b1);
    axi_rd(STATUS_OFS, rd, RESP_OKAY);
    chk(rd, stat_exp(1'b1, 1'b1, 1'b0));
    chk({31'h0, irq}, 32'h0);
    axi_rd(IRQ_STAT_OFS, rd, RESP_OKAY);
    chk(rd & 32'h2, 32'h2);
    // Isolate cleared, link up, receive error marked
    axi_wr(CTRL_OFS, 32'h0, RESP_OKAY);
    check_tx(1'b1, 1'b0);
    err_pulse();
    chk({31'h0, crx.er}, 32'h1);
    chk({31'h0, crx.en}, 32'h1);
    // Light lost: sync drops, transmit gated unless unidirectional
    light <= 1'b0;
    wait_sv(0, 1'b0, 20);
    wait_sv(1, 1'b0, 20);
    check_tx(1'b0, 1'b0);
    axi_rd(STATUS_OFS, rd, RESP_OKAY);
    chk(rd, stat_exp(1'b0, 1'b0, 1'b0));
    axi_wr(CTRL_OFS, 32'h2, RESP_OKAY);
    check_tx(1'b1, 1'b0);
    // Negotiation with interrupts unmasked
    axi_wr(IRQ_STAT_OFS, 32'h7, RESP_OKAY);
    axi_wr(IRQ_MASK_OFS, 32'h7, RESP_OKAY);
    light <= 1'b1;
    neg <= 1'b1;
    axi_wr(CTRL_OFS, 32'h4, RESP_OKAY);
    wait_sv(1, 1'b1, 300);
    axi_rd(STATUS_OFS, rd, RESP_OKAY);
    chk(rd, stat_exp(1'b1, 1'b1, 1'b1));
    chk({31'h0, irq}, 32'h1);
    axi_wr(IRQ_STAT_OFS, 32'h7, RESP_OKAY);
    repeat (2) @(posedge mclk);
    #1;
    chk({31'h0, irq}, 32'h0);
    // Restart, partner silent, bit error in the handshake
    neg <= 1'b0;
    axi_wr(CTRL_OFS, 32'hc, RESP_OKAY);
    repeat (LT + 12) @(posedge mclk);
    err_pulse();
    axi_rd(IRQ_STAT_OFS, rd, RESP_OKAY);
    chk(rd & 32'h4, 32'h4);
    axi_rd(STATUS_OFS, rd, RESP_OKAY);
    chk(rd, stat_exp(1'b1, 1'b0, 1'b0));
    give_verdict();
  end

endmodule // tb_pcs_link_status_gating
`default_nettype wire
